// [hw/pdmm_pkg.sv]
// constants and types for the program and data memory map block
// assumes a single core clock domain shared with fetch and data paths
package pdmm_pkg;
   // ==========================================================
   // program memory
   localparam int PC_W = 13;
   localparam int PROG_WORD_W = 14;
   localparam int SMALL_WORDS = 2048;
   localparam int LARGE_WORDS = 4096;
   localparam int HI_END_WORDS = 128;
   localparam logic [12:0] RESET_VEC = 13'h0000;
   localparam logic [12:0] INT_VEC = 13'h0004;
   // ==========================================================
   // data memory
   localparam int DADDR_W = 9;
   localparam logic [6:0] OFF_INDIRECT = 7'h00;
   localparam logic [6:0] OFF_PC_LOW = 7'h02;
   localparam logic [6:0] OFF_STATUS = 7'h03;
   localparam logic [6:0] OFF_POINTER = 7'h04;
   localparam logic [6:0] OFF_PC_HIGH = 7'h0A;
   localparam logic [6:0] OFF_INT_CTRL = 7'h0B;
   localparam logic [6:0] GPR_START = 7'h20;
   localparam logic [6:0] COMMON_START = 7'h70;
   localparam logic [6:0] SMALL_B1_END = 7'h3F;
   localparam logic [6:0] BANK_GPR_END = 7'h6F;
   localparam int COMMON_BYTES = 16;
   localparam int BANK_GPR_BYTES = 80;
   localparam int GPR_SMALL = 128;
   localparam int GPR_LARGE = 256;
   localparam int ST_IRP = 7;
   localparam int ST_BANK_HI = 6;
   localparam int ST_BANK_LO = 5;
   localparam int PCH_SEL_LO = 3;
   localparam logic [7:0] STATUS_RST = 8'h18;
   localparam logic [7:0] POINTER_RST = 8'h00;
   localparam logic [7:0] PC_HIGH_RST = 8'h00;
   localparam logic [7:0] INT_CTRL_RST = 8'h00;

   typedef enum logic [1:0] {
      PDMM_UNIMP = 2'b00,
      PDMM_CORE = 2'b01,
      PDMM_GPR = 2'b10
   } pdmm_kind_t;

   typedef struct packed {
      pdmm_kind_t kind;
      logic [7:0] idx;
   } pdmm_dec_t;

   typedef struct packed {
      logic we;
      logic indirect;
      logic [6:0] offset;
      logic [7:0] wdata;
   } pdmm_dreq_t;
endpackage : pdmm_pkg

// [hw/pdmm_top.sv]
// program counter, program address wrap and banked data memory decode
// assumes the core issues at most one data request per cycle, answered next cycle
`timescale 1ns/1ps
`default_nettype none
module pdmm_top #(
   parameter bit LARGE_VARIANT = 1'b1
) (
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic i_fetch_step,
   input wire logic i_jump,
   input wire logic [10:0] i_jump_target,
   input wire logic i_irq_take,
   input wire logic i_data_req,
   input wire pdmm_pkg::pdmm_dreq_t i_data_cmd,
   output logic [12:0] o_fetch_addr,
   output logic o_hi_endur,
   output logic [1:0] o_bank,
   output logic [7:0] o_data_rdata,
   output logic o_data_valid
);
   import pdmm_pkg::*;

   // ==========================================================
   // sizes
   localparam int WORDS = LARGE_VARIANT ? LARGE_WORDS : SMALL_WORDS;
   localparam logic [12:0] PC_MASK = 13'(WORDS - 1);
   localparam logic [12:0] HI_START = 13'(WORDS - HI_END_WORDS);
   localparam int GPR_BYTES = LARGE_VARIANT ? GPR_LARGE : GPR_SMALL;

   function automatic logic [12:0] pdmm_wrap(input logic [12:0] a);
      return a & PC_MASK;
   endfunction : pdmm_wrap

   // offset to RAM index: common first, then bank 0, 1, 2 blocks
   function automatic pdmm_dec_t pdmm_decode(input logic [8:0] a);
      pdmm_dec_t r;
      logic [6:0] off;
      logic [1:0] bank;
      r.kind = PDMM_UNIMP;
      r.idx = 8'h00;
      off = a[6:0];
      bank = a[8:7];
      if (off < GPR_START) begin
         if (off == OFF_INDIRECT || off == OFF_PC_LOW || off == OFF_STATUS ||
             off == OFF_POINTER || off == OFF_PC_HIGH || off == OFF_INT_CTRL) begin
            r.kind = PDMM_CORE;
         end
      end else if (off >= COMMON_START) begin
         r.kind = PDMM_GPR;
         r.idx = 8'(off - COMMON_START);
      end else if (bank == 2'b00 || (LARGE_VARIANT && bank != 2'b11) ||
                   (bank == 2'b01 && off <= SMALL_B1_END)) begin
         r.kind = PDMM_GPR;
         r.idx = 8'(COMMON_BYTES + 32'(bank) * BANK_GPR_BYTES + 32'(off - GPR_START));
      end
      return r;
   endfunction : pdmm_decode

   // ==========================================================
   // core registers and program counter
   logic [12:0] pc_q, pc_d;
   logic [7:0] status_q, status_d;
   logic [7:0] pointer_q, pointer_d;
   logic [7:0] pc_high_q, pc_high_d;
   logic [7:0] int_ctrl_q, int_ctrl_d;
   logic hi_endur_q, hi_endur_d;
   logic [7:0] rdata_q, rdata_d;
   logic valid_q, valid_d;
   logic [7:0] ram_q [GPR_LARGE];
   logic [8:0] daddr;
   pdmm_dec_t dec;
   logic self_ref;
   logic wr_ok;

   always_comb begin
      if (i_data_cmd.indirect) begin
         daddr = {status_q[ST_IRP], pointer_q};
      end else begin
         daddr = {status_q[ST_BANK_HI], status_q[ST_BANK_LO], i_data_cmd.offset};
      end
      self_ref = i_data_cmd.indirect && (daddr[6:0] == OFF_INDIRECT);
      dec = pdmm_decode(daddr);
      wr_ok = i_data_req && i_data_cmd.we && !self_ref;
   end

   always_comb begin
      pc_d = pc_q;
      status_d = status_q;
      pointer_d = pointer_q;
      pc_high_d = pc_high_q;
      int_ctrl_d = int_ctrl_q;
      rdata_d = 8'h00;
      valid_d = i_data_req;
      if (i_data_req && !self_ref && dec.kind == PDMM_CORE) begin
         unique case (daddr[6:0])
            OFF_PC_LOW: rdata_d = pc_q[7:0];
            OFF_STATUS: rdata_d = status_q;
            OFF_POINTER: rdata_d = pointer_q;
            OFF_PC_HIGH: rdata_d = pc_high_q;
            OFF_INT_CTRL: rdata_d = int_ctrl_q;
            default: rdata_d = 8'h00;
         endcase
      end else if (i_data_req && !self_ref && dec.kind == PDMM_GPR &&
                   32'(dec.idx) < GPR_BYTES) begin
         rdata_d = ram_q[dec.idx];
      end
      if (wr_ok && dec.kind == PDMM_CORE) begin
         unique case (daddr[6:0])
            OFF_STATUS: status_d = i_data_cmd.wdata;
            OFF_POINTER: pointer_d = i_data_cmd.wdata;
            OFF_PC_HIGH: pc_high_d = i_data_cmd.wdata;
            OFF_INT_CTRL: int_ctrl_d = i_data_cmd.wdata;
            default: pc_d = pc_d;
         endcase
      end
      if (i_fetch_step) begin
         pc_d = pdmm_wrap(pc_q + 13'h0001);
      end
      if (i_jump) begin
         pc_d = pdmm_wrap({pc_high_q[PCH_SEL_LO +: 2], i_jump_target});
      end
      if (wr_ok && dec.kind == PDMM_CORE && daddr[6:0] == OFF_PC_LOW) begin
         pc_d = pdmm_wrap({pc_high_q[4:0], i_data_cmd.wdata});
      end
      if (i_irq_take) begin
         pc_d = INT_VEC;
      end
      hi_endur_d = pc_d >= HI_START;
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         pc_q <= RESET_VEC;
         status_q <= STATUS_RST;
         pointer_q <= POINTER_RST;
         pc_high_q <= PC_HIGH_RST;
         int_ctrl_q <= INT_CTRL_RST;
         hi_endur_q <= 1'b0;
         rdata_q <= 8'h00;
         valid_q <= 1'b0;
      end else begin
         pc_q <= pc_d;
         status_q <= status_d;
         pointer_q <= pointer_d;
         pc_high_q <= pc_high_d;
         int_ctrl_q <= int_ctrl_d;
         hi_endur_q <= hi_endur_d;
         rdata_q <= rdata_d;
         valid_q <= valid_d;
      end
   end

   // ==========================================================
   // general RAM, unimplemented writes dropped
   always_ff @(posedge i_core_clk) begin
      if (wr_ok && dec.kind == PDMM_GPR && 32'(dec.idx) < GPR_BYTES) begin
         ram_q[dec.idx] <= i_data_cmd.wdata;
      end
   end

   assign o_fetch_addr = pc_q;
   assign o_hi_endur = hi_endur_q;
   assign o_bank = {status_q[ST_BANK_HI], status_q[ST_BANK_LO]};
   assign o_data_rdata = rdata_q;
   assign o_data_valid = valid_q;

   // ==========================================================
   // checks
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_srst);

   pc_in_range_a: assert property ((o_fetch_addr & ~PC_MASK) == 13'h0000)
      else $error("program counter outside implemented space");
   pc_wrap_a: assert property (i_fetch_step && !i_jump && !i_irq_take && !wr_ok &&
      o_fetch_addr == PC_MASK |=> o_fetch_addr == 13'h0000)
      else $error("program counter did not wrap");
   reset_vec_a: assert property (disable iff (1'b0) i_srst |=> o_fetch_addr == 13'h0000)
      else $error("reset did not start at zero");
   irq_vec_a: assert property (i_irq_take |=> o_fetch_addr == 13'h0004)
      else $error("interrupt did not vector to four");
   last_word_a: assert property (o_fetch_addr <= (LARGE_VARIANT ? 13'h0FFF : 13'h07FF))
      else $error("last program word wrong");
   hi_endur_a: assert property (o_hi_endur == (o_fetch_addr[11:7] ==
      (LARGE_VARIANT ? 5'h1F : 5'h0F)))
      else $error("high endurance flag wrong");
   bank_sel_a: assert property (!i_data_cmd.indirect |-> daddr[8:7] == o_bank)
      else $error("bank bits not used");
   sfr_low_a: assert property (daddr[6:0] < GPR_START |-> dec.kind != PDMM_GPR)
      else $error("special area decoded as ram");
   mirror_a: assert property (daddr[6:0] == OFF_POINTER |-> dec.kind == PDMM_CORE)
      else $error("core register not mirrored");
   ram_size_a: assert property (dec.kind == PDMM_GPR |-> 32'(dec.idx) < GPR_BYTES)
      else $error("ram index past size");
   ind_addr_a: assert property (i_data_req && i_data_cmd.indirect |->
      daddr == {status_q[ST_IRP], pointer_q})
      else $error("indirect address not from pointer");
   unimp_zero_a: assert property (i_data_req && dec.kind == PDMM_UNIMP |=>
      o_data_valid && o_data_rdata == 8'h00)
      else $error("unimplemented read not zero");
   common_a: assert property (daddr[6:0] >= COMMON_START |->
      dec.kind == PDMM_GPR && dec.idx == 8'(daddr[6:0] - COMMON_START))
      else $error("common ram not shared");

   irq_c: cover property (i_irq_take ##1 i_fetch_step);
   wrap_c: cover property (o_fetch_addr == PC_MASK ##1 o_fetch_addr == 13'h0000);
   ind_c: cover property (i_data_req && i_data_cmd.indirect && dec.kind == PDMM_GPR);
   bank3_c: cover property (i_data_req && o_bank == 2'b11 && dec.kind == PDMM_GPR);
endmodule : pdmm_top
`default_nettype wire

// [tb/pdmm_core_model.sv]
// core-side model: fetch control and data requests for pdmm_top
// assumes requests are taken at the rising edge of i_core_clk
`timescale 1ns/1ps
`default_nettype none
module pdmm_core_model (
   input wire logic i_core_clk,
   output var logic o_step,
   output var logic o_jump,
   output var logic [10:0] o_target,
   output var logic o_irq,
   output var logic o_req,
   output var pdmm_pkg::pdmm_dreq_t o_cmd
);
   import pdmm_pkg::*;
   // ==========================================================
   // idle values at time zero
   initial begin
      o_step = 1'b0;
      o_jump = 1'b0;
      o_target = 11'h000;
      o_irq = 1'b0;
      o_req = 1'b0;
      o_cmd = '0;
   end
   // ==========================================================
   // one cycle of requests; released fields show no stale value
   task automatic cyc(input logic rq, input pdmm_dreq_t c, input logic st, input logic jp,
                      input logic iq, input logic [10:0] tg);
      @(posedge i_core_clk);
      o_req <= rq;
      o_cmd <= rq ? c : ~o_cmd;
      o_step <= st;
      o_jump <= jp;
      o_irq <= iq;
      o_target <= jp ? tg : ~o_target;
   endtask : cyc
endmodule : pdmm_core_model
`default_nettype wire

// [tb/pdmm_top_test.sv]
// self-checking bench for pdmm_top, large variant
// assumes pdmm_core_model drives every core-side input
`timescale 1ns/1ps
`default_nettype none
module pdmm_top_test;
   import pdmm_pkg::*;
   typedef struct packed {logic chk; logic [7:0] val;} pdmm_exp_t;
   logic i_core_clk = 1'b0;
   logic i_srst = 1'b1;
   logic step, jump, irq, req, he, dv;
   logic [10:0] tgt, tg;
   pdmm_dreq_t cmd;
   logic [12:0] fetch;
   logic [1:0] bank;
   logic [7:0] rdata, cv;
   logic [7:0] v [4];
   pdmm_exp_t q[$];
   pdmm_exp_t e;
   int error_cnt = 0;
   int n_tests = 0;
   logic [31:0] seed = 32'hEE67E22A;
   // ==========================================================
   // clock, model and design
   always #25 i_core_clk = ~i_core_clk;
   pdmm_core_model m (.i_core_clk(i_core_clk), .o_step(step), .o_jump(jump),
      .o_target(tgt), .o_irq(irq), .o_req(req), .o_cmd(cmd));
   pdmm_top u_dut (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_fetch_step(step),
      .i_jump(jump), .i_jump_target(tgt), .i_irq_take(irq), .i_data_req(req),
      .i_data_cmd(cmd), .o_fetch_addr(fetch), .o_hi_endur(he), .o_bank(bank),
      .o_data_rdata(rdata), .o_data_valid(dv));
   // ==========================================================
   // helpers
   function automatic logic [7:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction : rnd
   task automatic report(input string s);
      error_cnt++;
      $display("FAIL %0t %s", $time, s);
   endtask : report
   task automatic cmp_data(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) report($sformatf("data %h exp %h", got, exp));
   endtask : cmp_data
   task automatic cmp_pc(input logic [13:0] exp);
      n_tests++;
      if ({fetch, he} !== exp) report($sformatf("pc %h exp %h", {fetch, he}, exp));
   endtask : cmp_pc
   task automatic cmp_bank(input logic [1:0] exp);
      n_tests++;
      if (bank !== exp) report($sformatf("bank %b exp %b", bank, exp));
   endtask : cmp_bank
   task automatic rd(input logic ind, input logic [6:0] off, input logic [7:0] x);
      m.cyc(1'b1, pdmm_dreq_t'{1'b0, ind, off, rnd()}, 1'b0, 1'b0, 1'b0, 11'h000);
      q.push_back(pdmm_exp_t'{1'b1, x});
   endtask : rd
   task automatic wr(input logic ind, input logic [6:0] off, input logic [7:0] d);
      m.cyc(1'b1, pdmm_dreq_t'{1'b1, ind, off, d}, 1'b0, 1'b0, 1'b0, 11'h000);
      q.push_back(pdmm_exp_t'{1'b0, 8'h00});
   endtask : wr
   task automatic pc(input logic st, input logic jp, input logic iq, input logic [10:0] t);
      m.cyc(1'b0, '0, st, jp, iq, t);
   endtask : pc
   task automatic finish_test();
      $display("errors %0d of %0d checks", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   // ==========================================================
   // monitor: oldest note against each data answer
   always @(posedge i_core_clk) begin
      if (dv === 1'b1) begin
         if (q.size() == 0) report("spurious data valid");
         else begin
            e = q.pop_front();
            if (e.chk) cmp_data(rdata, e.val);
         end
      end else if (dv !== 1'b0 && !i_srst) begin
         report("data valid unknown");
      end
   end
   // ==========================================================
   // main sequence
   initial begin
      repeat (8) @(posedge i_core_clk);
      i_srst <= 1'b0;
      #1 cmp_pc(14'h0000);
      cmp_bank(2'b00);
      pc(1'b1, 1'b1, 1'b1, 11'h7FF);
      pc(1'b1, 1'b0, 1'b0, 11'h000);
      #1 cmp_pc({13'h0004, 1'b0});
      pc(1'b0, 1'b0, 1'b0, 11'h000);
      #1 cmp_pc({13'h0005, 1'b0});
      cv = rnd();
      wr(1'b0, OFF_POINTER, 8'h25);
      wr(1'b1, OFF_INDIRECT, cv);
      rd(1'b0, 7'h25, cv);
      wr(1'b0, OFF_POINTER, 8'hA5);
      wr(1'b1, OFF_INDIRECT, ~cv);
      wr(1'b0, OFF_POINTER, 8'h80);
      rd(1'b1, OFF_INDIRECT, 8'h00);
      wr(1'b0, 7'h7F, cv);
      wr(1'b0, OFF_INT_CTRL, ~cv);
      for (int b = 0; b < 4; b++) begin
         v[b] = rnd();
         wr(1'b0, OFF_STATUS, {1'b0, 2'(b), 5'h18});
         rd(1'b0, OFF_STATUS, {1'b0, 2'(b), 5'h18});
         rd(1'b0, 7'h7F, cv);
         rd(1'b0, OFF_POINTER, 8'h80);
         rd(1'b0, OFF_INT_CTRL, ~cv);
         rd(1'b0, OFF_PC_LOW, 8'h05);
         rd(1'b0, 7'h01, 8'h00);
         wr(1'b0, 7'h20, v[b]);
         rd(1'b0, 7'h20, (b == 3) ? 8'h00 : v[b]);
         if (b == 1) rd(1'b0, 7'h25, ~cv);
         pc(1'b0, 1'b0, 1'b0, 11'h000);
         #1 cmp_bank(2'(b));
      end
      wr(1'b0, OFF_STATUS, 8'h18);
      rd(1'b0, 7'h20, v[0]);
      wr(1'b0, OFF_PC_HIGH, 8'h1F);
      rd(1'b0, OFF_PC_HIGH, 8'h1F);
      wr(1'b0, OFF_PC_LOW, 8'hFF);
      pc(1'b0, 1'b0, 1'b0, 11'h000);
      #1 cmp_pc({13'h0FFF, 1'b1});
      pc(1'b1, 1'b0, 1'b0, 11'h000);
      pc(1'b0, 1'b0, 1'b0, 11'h000);
      #1 cmp_pc({13'h0000, 1'b0});
      wr(1'b0, OFF_PC_HIGH, 8'h18);
      for (int i = 0; i < 3; i++) begin
         tg = (i == 0) ? 11'h77F : (i == 1) ? 11'h780 : {rnd(), 3'h5};
         pc(1'b0, 1'b1, 1'b0, tg);
         pc(1'b0, 1'b0, 1'b0, 11'h000);
         #1 cmp_pc({2'b01, tg, tg >= 11'h780});
      end
      @(posedge i_core_clk);
      i_srst <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      i_srst <= 1'b0;
      #1 cmp_pc(14'h0000);
      cmp_bank(2'b00);
      rd(1'b0, OFF_POINTER, POINTER_RST);
      rd(1'b0, OFF_PC_HIGH, PC_HIGH_RST);
      rd(1'b0, OFF_INT_CTRL, INT_CTRL_RST);
      repeat (3) @(posedge i_core_clk);
      if (q.size() != 0) report("missing data valid");
      finish_test();
   end
   // ==========================================================
   // watchdog
   initial begin
      repeat (2000) @(posedge i_core_clk);
      report("watchdog expired");
      finish_test();
   end
endmodule : pdmm_top_test
`default_nettype wire
